// ---- inc/status_queue_pkg.sv ----
// Constants for the status flag word and the result queue read port.
// Shared by the serial front end and the queue storage.
package status_queue_pkg;
    localparam int QUEUE_DEPTH = 16;
    localparam int QUEUE_AW = 4;
    localparam int WORD_W = 16;
    localparam int CMD_W = 8;
    localparam int FLAG_W = 7;
    localparam logic [7:0] CMD_QUEUE_READ = 8'h80;
    localparam logic [7:0] CMD_STATUS_READ = 8'hf6;
    // Status word bit positions
    localparam int BIT_REBOOT_SEEN = 6;
    localparam int BIT_ARITH_UNIT_ENGAGED = 5;
    localparam int BIT_GAIN_CAL_ACTIVE = 4;
    localparam int BIT_CONVERSION_ACTIVE = 3;
    localparam int BIT_GATE_CALC_ACTIVE = 2;
    localparam int BIT_QUEUE_EMPTY = 1;
    localparam int BIT_QUEUE_OVERFLOW = 0;
    localparam logic [6:0] STATUS_RESET = 7'h06;
    // Queue word layout
    localparam int TAG_MSB = 15;
    localparam int TAG_LSB = 12;
    localparam int VALUE_MSB = 11;
    localparam int CFG_VALUE_MSB = 12;
    localparam logic [3:0] TAG_CORRUPTED = 4'he;
    localparam logic [3:0] TAG_EMPTY = 4'hf;
    localparam logic [2:0] TAG_LOOKUP_TABLE = 3'h6;
    // Serial bit counts
    localparam logic [4:0] BITS_CMD = 5'h08;
    localparam logic [4:0] BITS_FRAME = 5'h18;
endpackage

// ---- hw/queue_mem.sv ----
// Result queue storage: one write port, one read port with registered data.
// Assumes a single clock; read data lags the read address by one edge.
`timescale 1ns/100ps
module queue_mem
    import status_queue_pkg::*;
(
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [QUEUE_AW-1:0] wr_addr,
    input wire logic [WORD_W-1:0] wr_data,
    input wire logic [QUEUE_AW-1:0] rd_addr,
    output logic [WORD_W-1:0] rd_data
);
    logic [WORD_W-1:0] mem [QUEUE_DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ---- hw/status_flags_and_result_queue_read.sv ----
// Status flag word and result queue, read by the host over a 4-wire serial port.
// Assumes the core delivers busy levels and one-cycle event pulses on this clock.
`timescale 1ns/100ps
module status_flags_and_result_queue_read
    import status_queue_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic ser_cs_n,
    input wire logic ser_clk,
    input wire logic ser_din,
    output logic ser_dout,
    output logic ser_dout_oe_n,
    input wire logic watchdog_reset_evt,
    input wire logic full_reinit_evt,
    input wire logic queue_flush,
    input wire logic arith_unit_engaged,
    input wire logic gain_cal_active,
    input wire logic conversion_active,
    input wire logic gate_calc_active,
    input wire logic lookup_table_readout,
    input wire logic res_valid,
    input wire logic [3:0] res_tag,
    input wire logic [12:0] res_value,
    input wire logic res_config,
    output logic res_ready,
    output logic [FLAG_W-1:0] status_word
);
    logic [2:0] cs_sync_r, clk_sync_r;
    logic [1:0] din_sync_r;
    logic [4:0] bit_cnt_r;
    logic [CMD_W-1:0] cmd_sh_r;
    logic [WORD_W-1:0] out_sh_r;
    logic [QUEUE_AW-1:0] wr_ptr_r, rd_ptr_r;
    logic [QUEUE_AW:0] count_r;
    logic reboot_seen_r, overflow_r, queue_read_active_r;
    logic [WORD_W-1:0] head_word;

    // Serial pins pass two flip-flops; the third stage only serves edge detection
    always_ff @(posedge clock) begin
        cs_sync_r <= {cs_sync_r[1:0], ser_cs_n};
        clk_sync_r <= {clk_sync_r[1:0], ser_clk};
        din_sync_r <= {din_sync_r[0], ser_din};
    end

    wire selected = !cs_sync_r[1];
    wire sclk_rise = selected && clk_sync_r[1] && !clk_sync_r[2];
    wire sclk_fall = selected && !clk_sync_r[1] && clk_sync_r[2];
    wire [CMD_W-1:0] cmd_next = {cmd_sh_r[CMD_W-2:0], din_sync_r[1]};
    wire cmd_done = sclk_rise && (bit_cnt_r == BITS_CMD - 5'h01);
    wire cmd_queue = cmd_done && (cmd_next == CMD_QUEUE_READ);
    wire cmd_status = cmd_done && (cmd_next == CMD_STATUS_READ);

    wire full = (count_r == (QUEUE_AW+1)'(QUEUE_DEPTH));
    wire empty = (count_r == '0);
    wire pop = cmd_queue && !empty;
    // Table readout refuses writes when full instead of overflowing
    wire accept = res_valid && !queue_flush && !(lookup_table_readout && full);
    wire ovf_evt = accept && full;
    // Overflow during a queue readout overwrites the newest slot, marked suspect
    wire ovf_mark = ovf_evt && queue_read_active_r;
    wire push = accept && !full;
    wire [QUEUE_AW-1:0] last_ptr = wr_ptr_r - QUEUE_AW'(1);

    wire [12:0] value_field = res_config ? res_value : {1'b0, res_value[VALUE_MSB:0]};
    wire [3:0] tag_field = res_config ? {TAG_LOOKUP_TABLE, res_value[CFG_VALUE_MSB]} : res_tag;
    wire [WORD_W-1:0] push_word = ovf_mark ? {TAG_CORRUPTED, value_field[VALUE_MSB:0]}
                                           : {tag_field, value_field[VALUE_MSB:0]};
    wire mem_wr = push || ovf_mark;
    wire [QUEUE_AW-1:0] mem_wr_addr = ovf_mark ? last_ptr : wr_ptr_r;

    wire ovf_bit = lookup_table_readout ? full : overflow_r;
    wire [FLAG_W-1:0] flags_now = {reboot_seen_r, arith_unit_engaged, gain_cal_active,
                                   conversion_active, gate_calc_active, empty, ovf_bit};
    wire [WORD_W-1:0] empty_word = {TAG_EMPTY, {(WORD_W-4-FLAG_W){1'b0}}, flags_now};
    wire [WORD_W-1:0] status_out = {{(WORD_W-FLAG_W){1'b0}}, flags_now};

    queue_mem u_queue_mem (
        .clock(clock),
        .wr_en(mem_wr),
        .wr_addr(mem_wr_addr),
        .wr_data(push_word),
        .rd_addr(rd_ptr_r),
        .rd_data(head_word)
    );

    // Serial command and bit counting
    always_ff @(posedge clock) begin
        if (!rstn || !selected) begin
            bit_cnt_r <= '0;
            cmd_sh_r <= '0;
            queue_read_active_r <= 1'b0;
        end else if (sclk_rise) begin
            if (bit_cnt_r < BITS_CMD) begin
                cmd_sh_r <= cmd_next;
            end
            if (bit_cnt_r != BITS_FRAME) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
            if (cmd_queue) begin
                queue_read_active_r <= 1'b1;
            end
        end
    end

    // Output word loads at command end and shifts out on falling edges, MSB first
    always_ff @(posedge clock) begin
        if (!rstn) begin
            out_sh_r <= '0;
            ser_dout <= 1'b0;
            ser_dout_oe_n <= 1'b1;
        end else begin
            ser_dout_oe_n <= !(selected && bit_cnt_r >= BITS_CMD);
            if (cmd_queue) begin
                out_sh_r <= empty ? empty_word : head_word;
            end else if (cmd_status) begin
                out_sh_r <= status_out;
            end else if (sclk_fall && bit_cnt_r >= BITS_CMD) begin
                ser_dout <= out_sh_r[WORD_W-1];
                out_sh_r <= {out_sh_r[WORD_W-2:0], 1'b0};
            end
        end
    end

    // Queue pointers; flush discards everything
    always_ff @(posedge clock) begin
        if (!rstn || queue_flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + QUEUE_AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + QUEUE_AW'(1);
            end
            count_r <= count_r + (QUEUE_AW+1)'(push) - (QUEUE_AW+1)'(pop);
        end
    end

    // Sticky flags: a set in the same cycle as a read clear wins
    always_ff @(posedge clock) begin
        if (!rstn) begin
            reboot_seen_r <= 1'b0;
            overflow_r <= 1'b0;
        end else begin
            if (watchdog_reset_evt || full_reinit_evt) begin
                reboot_seen_r <= 1'b1;
            end else if (cmd_status) begin
                reboot_seen_r <= 1'b0;
            end
            if (ovf_evt && !lookup_table_readout) begin
                overflow_r <= 1'b1;
            end else if (cmd_status || queue_flush) begin
                overflow_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            res_ready <= 1'b0;
            status_word <= STATUS_RESET;
        end else begin
            res_ready <= !(lookup_table_readout && full);
            status_word <= flags_now;
        end
    end
endmodule

// ---- test/sfq_asserts.sv ----
// Checker for the status word and queue ports of the flag block.
// Bound to the top module; one clock, synchronous active-low reset.
`timescale 1ns/100ps
module sfq_asserts
    import status_queue_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic ser_cs_n,
    input wire logic ser_dout_oe_n,
    input wire logic watchdog_reset_evt,
    input wire logic queue_flush,
    input wire logic arith_unit_engaged,
    input wire logic gate_calc_active,
    input wire logic lookup_table_readout,
    input wire logic res_valid,
    input wire logic res_ready,
    input wire logic [FLAG_W-1:0] status_word
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    chk_reset_value: assert property ($rose(rstn) |-> status_word == STATUS_RESET)
        else $error("bad reset flags");
    chk_arith_follow: assert property ($past(rstn) |-> status_word[5] == $past(arith_unit_engaged))
        else $error("arith bit wrong");
    chk_gate_follow: assert property ($past(rstn) |-> status_word[2] == $past(gate_calc_active))
        else $error("gate bit wrong");
    chk_reboot_set: assert property (watchdog_reset_evt |-> ##2 status_word[6])
        else $error("reboot not set");
    chk_empty_drop: assert property (res_valid && res_ready && !queue_flush |-> ##2 !status_word[1])
        else $error("empty not cleared");
    chk_flush_clear: assert property (queue_flush |-> ##2 status_word[1:0] == 2'b10)
        else $error("flush flags wrong");
    chk_ovf_hold: assert property (status_word[0] && ser_cs_n && !queue_flush && !lookup_table_readout
        && !$past(lookup_table_readout) && !$past(queue_flush) |=> status_word[0])
        else $error("overflow dropped");
    chk_dout_idle: assert property (ser_cs_n [*6] |-> ser_dout_oe_n)
        else $error("dout driven idle");
endmodule
bind status_flags_and_result_queue_read sfq_asserts i_sfq_asserts (.*);

// ---- test/host_model.sv ----
// Serial host: command byte then 16 read clocks, MSB first.
// Bit period is 16 system clocks, slower than the port allows.
`timescale 1ns/100ps
module host_model (
    input wire logic clock,
    output logic ser_cs_n = 1'b1,
    output logic ser_clk = 1'b0,
    output logic ser_din = 1'b0,
    input wire logic ser_dout,
    input wire logic ser_dout_oe_n
);
    task automatic xfer(input logic [7:0] cmd, output logic [15:0] word);
        ser_cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            repeat (8) @(posedge clock);
            ser_din <= (i > 15) ? cmd[i-16] : 1'b0;
            ser_clk <= 1'b0;
            repeat (8) @(posedge clock);
            // A released output line reads back inverted
            if (i < 16) word[i] = ser_dout_oe_n ? !ser_dout : ser_dout;
            ser_clk <= 1'b1;
        end
        repeat (8) @(posedge clock);
        ser_clk <= 1'b0;
        ser_cs_n <= 1'b1;
        ser_din <= ~ser_din;
        repeat (8) @(posedge clock);
    endtask
endmodule

// ---- test/status_flags_and_result_queue_read_tb.sv ----
// Bench for the flag word and result queue read path.
// Host model drives the serial pins; bench drives the core side.
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module status_flags_and_result_queue_read_tb
    import status_queue_pkg::*;
;
    typedef struct {logic [3:0] busy; logic [3:0] tag; logic [12:0] val; logic cfg; logic [15:0] word;} row_s;
    row_s rows[4] = '{'{4'ha, 4'h0, 13'h0abc, 1'b0, 16'h0abc}, '{4'h5, 4'ha, 13'h1fff, 1'b0, 16'hafff},
        '{4'h3, 4'h3, 13'h1234, 1'b1, 16'hd234}, '{4'hc, 4'h5, 13'h0001, 1'b1, 16'hc001}};
    logic clock = 0, rstn = 0, watchdog_reset_evt = 0, full_reinit_evt = 0, queue_flush = 0;
    logic lookup_table_readout = 0, res_valid = 0, res_config = 0;
    logic [3:0] busy = 0, res_tag = 0;
    logic [12:0] res_value = 0;
    logic ser_cs_n, ser_clk, ser_din, ser_dout, ser_dout_oe_n, res_ready;
    logic [FLAG_W-1:0] status_word;
    logic [15:0] w;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    status_flags_and_result_queue_read i_status_flags_and_result_queue_read (.*, .arith_unit_engaged(busy[3]),
        .gain_cal_active(busy[2]), .conversion_active(busy[1]), .gate_calc_active(busy[0]));
    host_model i_host_model (.*);
    task automatic push(input logic [3:0] t, input logic [12:0] v, input logic c);
        @(posedge clock);
        res_valid <= 1'b1;
        res_tag <= t;
        res_value <= v;
        res_config <= c;
        @(posedge clock);
        res_valid <= 1'b0;
    endtask
    task automatic pulse(input int k);
        @(posedge clock);
        {queue_flush, full_reinit_evt, watchdog_reset_evt} <= 3'(1 << k);
        @(posedge clock);
        {queue_flush, full_reinit_evt, watchdog_reset_evt} <= 3'h0;
        repeat (2) @(posedge clock);
    endtask
    task automatic test_done();
        if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial forever #2.5 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        `CHK(status_word, STATUS_RESET)
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        foreach (rows[i]) begin
            busy <= rows[i].busy;
            push(rows[i].tag, rows[i].val, rows[i].cfg);
            @(posedge clock);
            `CHK(status_word[5:2], rows[i].busy)
        end
        busy <= 4'h0;
        foreach (rows[i]) begin
            i_host_model.xfer(CMD_QUEUE_READ, w);
            `CHK(w, rows[i].word)
        end
        i_host_model.xfer(CMD_QUEUE_READ, w);
        `CHK(w, 16'hf002)
        pulse(0);
        i_host_model.xfer(CMD_STATUS_READ, w);
        `CHK(w, 16'h0042)
        i_host_model.xfer(CMD_STATUS_READ, w);
        `CHK(w, 16'h0002)
        pulse(1);
        `CHK(status_word[6], 1'b1)
        i_host_model.xfer(CMD_STATUS_READ, w);
        repeat (17) push(4'h1, 13'h0055, 1'b0);
        repeat (2) @(posedge clock);
        `CHK(status_word[0], 1'b1)
        i_host_model.xfer(CMD_QUEUE_READ, w);
        `CHK(w, 16'h1055)
        `CHK(status_word[0], 1'b1)
        i_host_model.xfer(CMD_STATUS_READ, w);
        `CHK(w, 16'h0001)
        `CHK(status_word[0], 1'b0)
        pulse(2);
        `CHK(status_word[1:0], 2'b10)
        i_host_model.xfer(CMD_QUEUE_READ, w);
        `CHK(w, 16'hf002)
        lookup_table_readout <= 1'b1;
        repeat (17) push(4'h2, 13'h0077, 1'b0);
        repeat (2) @(posedge clock);
        `CHK({res_ready, status_word[0]}, 2'b01)
        i_host_model.xfer(CMD_QUEUE_READ, w);
        `CHK({w, status_word[0]}, 17'h040ee)
        pulse(2);
        lookup_table_readout <= 1'b0;
        repeat (16) push(4'h3, 13'h0011, 1'b0);
        // Two results arrive while a queue read frame is open: refill, then overflow
        fork
            i_host_model.xfer(CMD_QUEUE_READ, w);
            begin
                repeat (200) @(posedge clock);
                push(4'h4, 13'h0022, 1'b0);
                push(4'h4, 13'h0033, 1'b0);
            end
        join
        `CHK(w, 16'h3011)
        repeat (15) i_host_model.xfer(CMD_QUEUE_READ, w);
        `CHK(w, 16'h3011)
        i_host_model.xfer(CMD_QUEUE_READ, w);
        `CHK(w, 16'he033)
        `CHK(status_word[0], 1'b1)
        test_done();
    end
endmodule
